// [usbr_pkg.sv]
// Package for the USB setup/OUT transaction engine and its register file
// Operation
// - Control limit four bits, general limit seven
// - General endpoint number, direction, policy, enable
// - Two-bit field sets buffer read cycles
// - Write one clears flag; enables gate interrupt
// - Per-endpoint request enables for buffer writes/reads
// - Reset-release zero holds USB circuit in reset
// - Bus-power bit zero masks USB logic
// - Engine answers from buffer count or space
// - Eight setup bytes land in setup registers
// - Clean setup gets automatic ACK
// - Setup sets flag, busy, sequence; clears halt
// - Faulty setup: no reply, nothing changes
// - OUT stores regardless of space until full
// - Good OUT: ACK, commit bytes, acked flag
// - Short packet sets short flag, maybe busy
// - Sequence mismatch: ACK, discard, set nothing
// - Buffer full: NAK, discard, refused flag only
// - OUT fault: no reply, discard, fault flag
// - Reset-release one takes circuit out of reset
// - Bus-power bit one opens register access
`default_nettype none
package usbr_pkg;
	localparam int NUM_EP = 4;
	localparam int BUF_DEPTH = 64;
	localparam int SETUP_LEN = 8;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_POWER = 8'h04;
	localparam logic [7:0] OFS_LINE = 8'h08;
	localparam logic [7:0] OFS_MAIN_FLAG = 8'h10;
	localparam logic [7:0] OFS_MAIN_EN = 8'h14;
	localparam logic [7:0] OFS_EP0_IN_CTL = 8'h18;
	localparam logic [7:0] OFS_SETUP_LO = 8'h20;
	localparam logic [7:0] OFS_SETUP_HI = 8'h24;
	localparam logic [7:0] OFS_WR_REQ_EN = 8'h28;
	localparam logic [7:0] OFS_RD_REQ_EN = 8'h2c;
	localparam logic [7:0] OFS_EP_BASE = 8'h40;
	localparam logic [7:0] OFS_FIFO_BASE = 8'h80;
	localparam logic [7:0] OFS_LEVEL_BASE = 8'h90;
	// Endpoint block sub-offsets (address bits 3:2)
	localparam logic [1:0] SUB_CFG = 2'h0;
	localparam logic [1:0] SUB_CTL = 2'h1;
	localparam logic [1:0] SUB_FLAG = 2'h2;
	localparam logic [1:0] SUB_FEN = 2'h3;
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_AUTO_BIT = 1;
	localparam int CTRL_WAIT_LSB = 2;
	localparam int POW_REL_BIT = 0;
	localparam int POW_VBUS_BIT = 1;
	localparam int CFG_DIR_BIT = 7;
	localparam int CFG_NUM_LSB = 8;
	localparam int CFG_POL_BIT = 12;
	localparam int CFG_ON_BIT = 13;
	localparam int CTL_BUSY_BIT = 0;
	localparam int CTL_HALT_BIT = 1;
	localparam int CTL_SEQ_BIT = 2;
	localparam int CTL_ABD_BIT = 3;
	localparam int FLG_ACK_BIT = 0;
	localparam int FLG_SHORT_BIT = 1;
	localparam int FLG_REF_BIT = 2;
	localparam int FLG_FAULT_BIT = 3;
	localparam logic [31:0] RESET_WORD = 32'h0;
	localparam logic [1:0] LINE_J = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {HS_ACK = 2'h0, HS_NAK = 2'h1, HS_STALL = 2'h2} usbr_hs_code_t;
	typedef enum {ST_IDLE, ST_DATA} usbr_state_t;
	// Decoded packet stream from the serial engine
	typedef struct packed {
		logic tok_valid;
		logic tok_setup;
		logic [3:0] tok_ep;
		logic data_odd;
		logic byte_valid;
		logic [7:0] data;
		logic pkt_end;
		logic pkt_err;
	} usbr_rx_t;
	// Handshake request to the serial engine
	typedef struct packed {
		logic valid;
		usbr_hs_code_t code;
	} usbr_hs_t;
endpackage
`default_nettype wire

// [usbr_top.sv]
// USB setup/OUT transaction engine with endpoint buffers and AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
`default_nettype none
module usbr_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic [usbr_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [usbr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire usbr_pkg::usbr_rx_t rx,
	output usbr_pkg::usbr_hs_t hs,
	input wire logic [1:0] bus_line_state,
	output logic usb_irq,
	output logic [usbr_pkg::NUM_EP-1:0] dma_wr_req,
	output logic [usbr_pkg::NUM_EP-1:0] dma_rd_req,
	output logic circuit_run,
	output logic logic_connected
);
	import usbr_pkg::*;

	// Power and reset-release bits, reset only by the system reset
	logic rel_q, vbus_q;
	// USB-side state: control, endpoints, flags
	logic ctrl_en_q, auto_q;
	logic [1:0] rwait_cfg_q;
	logic [1:0] line_s1_q, line_s2_q;
	logic setup_flag_q, setup_en_q;
	logic [2:0] in0_ctl_q;
	logic [7:0] setup_q [SETUP_LEN];
	logic [NUM_EP-1:0] wr_req_en_q, rd_req_en_q;
	logic [13:0] cfg_q [NUM_EP];
	logic [3:0] ctl_q [NUM_EP];
	logic [3:0] flag_q [NUM_EP];
	logic [3:0] fen_q [NUM_EP];
	logic [5:0] rdp_q [NUM_EP];
	logic [6:0] cnt_q [NUM_EP];
	logic [7:0] mem [NUM_EP*BUF_DEPTH];
	// Transaction engine
	usbr_state_t st_q;
	logic tsetup_q, thit_q, ovf_q;
	logic [1:0] tep_q;
	logic [6:0] wtmp_q;
	logic [3:0] scnt_q;
	logic [7:0] stmp_q [SETUP_LEN];
	// AXI channel state
	logic [7:0] awaddr_q, araddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_have_q, w_have_q, rbusy_q;
	logic [1:0] rcnt_q;
	logic usb_rst;

	// Circuit held in reset while release bit is low
	assign usb_rst = srst | ~rel_q;

	// Register view for reads and write merging
	function automatic logic [31:0] reg_view(input logic [7:0] a);
		logic [31:0] v;
		logic [1:0] k;
		v = RESET_WORD;
		k = a[5:4];
		if (a == OFS_POWER) begin
			v[POW_REL_BIT] = rel_q;
			v[POW_VBUS_BIT] = vbus_q;
		end else if (!vbus_q) begin
			v = RESET_WORD;
		end else if (a == OFS_CTRL) begin
			v[CTRL_EN_BIT] = ctrl_en_q;
			v[CTRL_AUTO_BIT] = auto_q;
			v[CTRL_WAIT_LSB +: 2] = rwait_cfg_q;
		end else if (a == OFS_LINE) begin
			v[1:0] = line_s2_q;
		end else if (a == OFS_MAIN_FLAG) begin
			v[0] = setup_flag_q;
		end else if (a == OFS_MAIN_EN) begin
			v[0] = setup_en_q;
		end else if (a == OFS_EP0_IN_CTL) begin
			v[2:0] = in0_ctl_q;
		end else if (a == OFS_SETUP_LO) begin
			v = {setup_q[3], setup_q[2], setup_q[1], setup_q[0]};
		end else if (a == OFS_SETUP_HI) begin
			v = {setup_q[7], setup_q[6], setup_q[5], setup_q[4]};
		end else if (a == OFS_WR_REQ_EN) begin
			v[NUM_EP-1:0] = wr_req_en_q;
		end else if (a == OFS_RD_REQ_EN) begin
			v[NUM_EP-1:0] = rd_req_en_q;
		end else if (a[7:6] == OFS_EP_BASE[7:6]) begin
			if (a[3:2] == SUB_CFG) begin
				v[13:0] = cfg_q[k];
			end else if (a[3:2] == SUB_CTL) begin
				v[3:0] = ctl_q[k];
			end else if (a[3:2] == SUB_FLAG) begin
				v[3:0] = flag_q[k];
			end else begin
				v[3:0] = fen_q[k];
			end
		end else if (a[7:4] == OFS_FIFO_BASE[7:4]) begin
			v[7:0] = mem[{a[3:2], rdp_q[a[3:2]]}];
		end else if (a[7:4] == OFS_LEVEL_BASE[7:4]) begin
			v[6:0] = cnt_q[a[3:2]];
		end
		return v;
	endfunction

	// Address map membership
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a == OFS_CTRL || a == OFS_POWER || a == OFS_LINE
			|| a == OFS_MAIN_FLAG || a == OFS_MAIN_EN || a == OFS_EP0_IN_CTL
			|| a == OFS_SETUP_LO || a == OFS_SETUP_HI || a == OFS_WR_REQ_EN
			|| a == OFS_RD_REQ_EN || a[7:6] == OFS_EP_BASE[7:6]
			|| a[7:4] == OFS_FIFO_BASE[7:4] || a[7:4] == OFS_LEVEL_BASE[7:4]);
	endfunction

	// AXI write channel handshakes
	logic aw_take, w_take, do_write, aw_have_d, w_have_d, bvalid_d;
	logic [31:0] wmask, wmerge, w1c, wview;
	logic [1:0] wk;
	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
	assign aw_have_d = (aw_have_q & ~do_write) | aw_take;
	assign w_have_d = (w_have_q & ~do_write) | w_take;
	assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// Addressed register contents; a process so state read inside the function is seen
	always_comb begin
		wview = reg_view(awaddr_q);
	end
	assign wmerge = (wview & ~wmask) | (wdata_q & wmask);
	assign w1c = wdata_q & wmask;
	assign wk = awaddr_q[5:4];

	// Write decode; USB registers only once bus power is seen
	logic wr_pow, wr_ctrl, wr_mflag, wr_men, wr_in0, wr_wre, wr_rde, wr_ep;
	assign wr_pow = do_write & (awaddr_q == OFS_POWER);
	assign wr_ctrl = do_write & vbus_q & (awaddr_q == OFS_CTRL);
	assign wr_mflag = do_write & vbus_q & (awaddr_q == OFS_MAIN_FLAG);
	assign wr_men = do_write & vbus_q & (awaddr_q == OFS_MAIN_EN);
	assign wr_in0 = do_write & vbus_q & (awaddr_q == OFS_EP0_IN_CTL);
	assign wr_wre = do_write & vbus_q & (awaddr_q == OFS_WR_REQ_EN);
	assign wr_rde = do_write & vbus_q & (awaddr_q == OFS_RD_REQ_EN);
	assign wr_ep = do_write & vbus_q & (awaddr_q[7:6] == OFS_EP_BASE[7:6])
		& (awaddr_q[1:0] == 2'h0);

	// AXI read: buffer reads wait the programmed cycles
	logic ar_take, r_fire, r_done, pop;
	logic [1:0] pk;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign r_fire = rbusy_q & ~s_axi_rvalid & (rcnt_q == 2'h0);
	assign r_done = s_axi_rvalid & s_axi_rready;
	assign pk = araddr_q[3:2];
	assign pop = r_fire & vbus_q & (araddr_q[7:4] == OFS_FIFO_BASE[7:4])
		& (cnt_q[pk] != 7'h0);

	// Endpoint match for an incoming token
	logic tok_hit;
	logic [1:0] tok_k;
	always_comb begin
		tok_hit = (rx.tok_ep == 4'h0);
		tok_k = 2'h0;
		for (int k = 1; k < NUM_EP; k++) begin
			if (!rx.tok_setup && cfg_q[k][CFG_ON_BIT] && !cfg_q[k][CFG_DIR_BIT]
				&& cfg_q[k][CFG_NUM_LSB +: 4] == rx.tok_ep && rx.tok_ep != 4'h0) begin
				tok_hit = 1'b1;
				tok_k = k[1:0];
			end
		end
	end

	// Engine runs only when enabled and reset released
	logic live, tok_go, fin;
	assign live = rel_q & vbus_q & ctrl_en_q & auto_q;
	assign tok_go = (st_q == ST_IDLE) & live & rx.tok_valid & tok_hit
		& (!rx.tok_setup | rx.tok_ep == 4'h0);
	assign fin = (st_q == ST_DATA) & rx.pkt_end;

	// Storing OUT bytes until the buffer is full
	logic busy_t, halt_t, seq_t, pol_t, store, mem_we;
	logic [7:0] fill, lim;
	logic [7:0] mem_wa;
	assign busy_t = ctl_q[tep_q][CTL_BUSY_BIT];
	assign halt_t = ctl_q[tep_q][CTL_HALT_BIT];
	assign seq_t = ctl_q[tep_q][CTL_SEQ_BIT];
	assign pol_t = (tep_q != 2'h0) & cfg_q[tep_q][CFG_POL_BIT];
	assign fill = {1'b0, cnt_q[tep_q]} + {1'b0, wtmp_q};
	assign store = (st_q == ST_DATA) & rx.byte_valid & ~rx.pkt_end & ~tsetup_q
		& ~busy_t & ~halt_t & ~ovf_q;
	assign mem_we = store & (fill < 8'(BUF_DEPTH));
	assign mem_wa = {tep_q, 6'(rdp_q[tep_q] + fill[5:0])};
	// Packet limits: control in units of eight bytes
	assign lim = (tep_q == 2'h0) ? {1'b0, cfg_q[0][3:0], 3'h0} : {1'b0, cfg_q[tep_q][6:0]};

	// End-of-packet decision
	logic hs_v, ev_setup, ev_commit, ev_short, ev_ref, ev_fault, ev_busy;
	usbr_hs_code_t hs_c;
	always_comb begin
		hs_v = 1'b0;
		hs_c = HS_ACK;
		ev_setup = 1'b0;
		ev_commit = 1'b0;
		ev_short = 1'b0;
		ev_ref = 1'b0;
		ev_fault = 1'b0;
		ev_busy = 1'b0;
		if (fin && tsetup_q) begin
			if (!rx.pkt_err && scnt_q == 4'(SETUP_LEN)) begin
				hs_v = 1'b1;
				ev_setup = 1'b1;
			end // Faulty setup: silent, nothing touched
		end else if (fin && thit_q) begin
			if (rx.pkt_err) begin
				ev_fault = 1'b1; // Corrupt data never answered, even when halted
			end else if (halt_t) begin
				hs_v = 1'b1;
				hs_c = HS_STALL;
			end else if (busy_t || ovf_q) begin
				hs_v = 1'b1;
				hs_c = HS_NAK;
				ev_ref = 1'b1;
			end else if (!pol_t && rx.data_odd != seq_t) begin
				hs_v = 1'b1; // Mismatch: ACK, data dropped
			end else begin
				hs_v = 1'b1;
				ev_commit = 1'b1;
				ev_short = (tep_q != 2'h0) && ({1'b0, wtmp_q} < lim);
				ev_busy = ev_short & ~ctl_q[tep_q][CTL_ABD_BIT];
			end
		end
	end

	// Endpoint state next values; hardware set wins over software clear
	logic [13:0] cfg_d [NUM_EP];
	logic [3:0] ctl_d [NUM_EP];
	logic [3:0] flag_d [NUM_EP];
	logic [3:0] fen_d [NUM_EP];
	logic [5:0] rdp_d [NUM_EP];
	logic [6:0] cnt_d [NUM_EP];
	always_comb begin
		for (int k = 0; k < NUM_EP; k++) begin
			logic sel, hit;
			sel = wr_ep & (wk == k[1:0]);
			hit = (tep_q == k[1:0]);
			cfg_d[k] = (sel && awaddr_q[3:2] == SUB_CFG)
				? ((k == 0) ? {10'h0, wmerge[3:0]} : wmerge[13:0]) : cfg_q[k];
			ctl_d[k] = (sel && awaddr_q[3:2] == SUB_CTL) ? wmerge[3:0] : ctl_q[k];
			fen_d[k] = (sel && awaddr_q[3:2] == SUB_FEN) ? wmerge[3:0] : fen_q[k];
			flag_d[k] = flag_q[k];
			if (sel && awaddr_q[3:2] == SUB_FLAG) begin
				flag_d[k] = flag_q[k] & ~w1c[3:0];
			end
			if (hit && ev_commit) begin
				flag_d[k][FLG_ACK_BIT] = 1'b1;
				ctl_d[k][CTL_SEQ_BIT] = ~seq_t; // Sequence advances on accepted data
			end
			if (hit && ev_short) begin
				flag_d[k][FLG_SHORT_BIT] = 1'b1;
			end
			if (hit && ev_busy) begin
				ctl_d[k][CTL_BUSY_BIT] = 1'b1;
			end
			if (hit && ev_ref) begin
				flag_d[k][FLG_REF_BIT] = 1'b1;
			end
			if (hit && ev_fault) begin
				flag_d[k][FLG_FAULT_BIT] = 1'b1;
			end
			if (k == 0 && ev_setup) begin
				ctl_d[k][CTL_BUSY_BIT] = 1'b1;
				ctl_d[k][CTL_HALT_BIT] = 1'b0;
				ctl_d[k][CTL_SEQ_BIT] = 1'b1;
			end
			// Commit makes bytes readable; pop frees one
			cnt_d[k] = cnt_q[k] + ((hit && ev_commit) ? wtmp_q : 7'h0)
				- ((pop && pk == k[1:0]) ? 7'h1 : 7'h0);
			rdp_d[k] = rdp_q[k] + ((pop && pk == k[1:0]) ? 6'h1 : 6'h0);
		end
	end

	// Power control bits, system reset only
	always_ff @(posedge clk) begin
		if (srst) begin
			rel_q <= 1'b0;
			vbus_q <= 1'b0;
		end else if (wr_pow) begin
			rel_q <= wmerge[POW_REL_BIT];
			vbus_q <= wmerge[POW_VBUS_BIT];
		end
	end

	// Line state synchroniser, read by software before enabling
	always_ff @(posedge clk) begin
		if (srst) begin
			line_s1_q <= 2'h0;
			line_s2_q <= 2'h0;
		end else begin
			line_s1_q <= bus_line_state;
			line_s2_q <= line_s1_q;
		end
	end

	// Control, main flag, request enables and endpoint registers
	always_ff @(posedge clk) begin
		if (usb_rst) begin
			ctrl_en_q <= 1'b0;
			auto_q <= 1'b0;
			rwait_cfg_q <= 2'h0;
			setup_flag_q <= 1'b0;
			setup_en_q <= 1'b0;
			in0_ctl_q <= 3'h0;
			wr_req_en_q <= '0;
			rd_req_en_q <= '0;
			for (int k = 0; k < NUM_EP; k++) begin
				cfg_q[k] <= 14'h0;
				ctl_q[k] <= 4'h0;
				flag_q[k] <= 4'h0;
				fen_q[k] <= 4'h0;
				rdp_q[k] <= 6'h0;
				cnt_q[k] <= 7'h0;
			end
		end else begin
			if (wr_ctrl) begin
				ctrl_en_q <= wmerge[CTRL_EN_BIT];
				auto_q <= wmerge[CTRL_AUTO_BIT];
				rwait_cfg_q <= wmerge[CTRL_WAIT_LSB +: 2];
			end
			setup_flag_q <= ev_setup | (setup_flag_q & ~(wr_mflag & w1c[0]));
			if (wr_men) begin
				setup_en_q <= wmerge[0];
			end
			if (ev_setup) begin
				in0_ctl_q <= 3'h5; // Busy and sequence set, halt cleared
			end else if (wr_in0) begin
				in0_ctl_q <= wmerge[2:0];
			end
			if (wr_wre) begin
				wr_req_en_q <= wmerge[NUM_EP-1:0];
			end
			if (wr_rde) begin
				rd_req_en_q <= wmerge[NUM_EP-1:0];
			end
			for (int k = 0; k < NUM_EP; k++) begin
				cfg_q[k] <= cfg_d[k];
				ctl_q[k] <= ctl_d[k];
				flag_q[k] <= flag_d[k];
				fen_q[k] <= fen_d[k];
				rdp_q[k] <= rdp_d[k];
				cnt_q[k] <= cnt_d[k];
			end
		end
	end

	// Setup bytes copied only after a clean setup packet
	always_ff @(posedge clk) begin
		if (usb_rst) begin
			for (int i = 0; i < SETUP_LEN; i++) begin
				setup_q[i] <= 8'h0;
			end
		end else if (ev_setup) begin
			for (int i = 0; i < SETUP_LEN; i++) begin
				setup_q[i] <= stmp_q[i];
			end
		end
	end

	// Endpoint buffer storage
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= rx.data;
		end
	end

	// Transaction engine sequencing
	always_ff @(posedge clk) begin
		if (usb_rst) begin
			st_q <= ST_IDLE;
			tsetup_q <= 1'b0;
			thit_q <= 1'b0;
			tep_q <= 2'h0;
			wtmp_q <= 7'h0;
			ovf_q <= 1'b0;
			scnt_q <= 4'h0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (tok_go) begin
						st_q <= ST_DATA;
						tsetup_q <= rx.tok_setup;
						thit_q <= 1'b1;
						tep_q <= tok_k;
						wtmp_q <= 7'h0;
						ovf_q <= 1'b0;
						scnt_q <= 4'h0;
					end
				end
				ST_DATA: begin
					if (rx.pkt_end) begin
						st_q <= ST_IDLE;
						thit_q <= 1'b0;
					end else if (rx.byte_valid && tsetup_q) begin
						scnt_q <= (scnt_q == 4'hf) ? scnt_q : scnt_q + 4'h1;
					end else if (mem_we) begin
						wtmp_q <= wtmp_q + 7'h1;
					end else if (store) begin
						ovf_q <= 1'b1; // Full: reception suspended
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Setup staging bytes
	always_ff @(posedge clk) begin
		if ((st_q == ST_DATA) && tsetup_q && rx.byte_valid && !rx.pkt_end
			&& scnt_q < 4'(SETUP_LEN)) begin
			stmp_q[scnt_q[2:0]] <= rx.data;
		end
	end

	// Handshake, interrupt and request outputs
	always_ff @(posedge clk) begin
		if (usb_rst) begin
			hs <= '0;
			usb_irq <= 1'b0;
			dma_wr_req <= '0;
			dma_rd_req <= '0;
		end else begin
			hs.valid <= hs_v;
			hs.code <= hs_c;
			usb_irq <= (setup_flag_q & setup_en_q)
				| (|((flag_q[0] & fen_q[0]) | (flag_q[1] & fen_q[1])
				| (flag_q[2] & fen_q[2]) | (flag_q[3] & fen_q[3])));
			for (int k = 0; k < NUM_EP; k++) begin
				dma_wr_req[k] <= wr_req_en_q[k] & (cnt_q[k] < 7'(BUF_DEPTH));
				dma_rd_req[k] <= rd_req_en_q[k] & (cnt_q[k] != 7'h0);
			end
		end
	end

	// Power state outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			circuit_run <= 1'b0;
			logic_connected <= 1'b0;
		end else begin
			circuit_run <= rel_q;
			logic_connected <= vbus_q;
		end
	end

	// AXI4-Lite slave channels
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_q <= 8'h0;
			wdata_q <= RESET_WORD;
			wstrb_q <= 4'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RESET_WORD;
			s_axi_rresp <= RESP_OKAY;
			araddr_q <= 8'h0;
			rbusy_q <= 1'b0;
			rcnt_q <= 2'h0;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			s_axi_awready <= ~aw_have_d;
			s_axi_wready <= ~w_have_d;
			s_axi_bvalid <= bvalid_d;
			if (aw_take) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bresp <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			s_axi_arready <= ~rbusy_q & ~ar_take;
			if (ar_take) begin
				araddr_q <= s_axi_araddr;
				rbusy_q <= 1'b1;
				rcnt_q <= (s_axi_araddr[7:4] == OFS_FIFO_BASE[7:4]) ? rwait_cfg_q : 2'h0;
			end else if (rbusy_q && rcnt_q != 2'h0) begin
				rcnt_q <= rcnt_q - 2'h1;
			end
			if (r_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= reg_view(araddr_q);
				s_axi_rresp <= mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
			end else if (r_done) begin
				s_axi_rvalid <= 1'b0;
				rbusy_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [usbr_chk.sv]
// Checker of bus and handshake timing for the USB transaction engine
`default_nettype none
module usbr_chk import usbr_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [usbr_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire usbr_pkg::usbr_rx_t rx,
	input wire usbr_pkg::usbr_hs_t hs,
	input wire logic circuit_run
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// Acceptance events on the bus and the link
	sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_rd_reg; s_axi_arvalid && s_axi_arready && s_axi_araddr < OFS_FIFO_BASE; endsequence
	sequence s_good_end; rx.pkt_end && !rx.pkt_err; endsequence
	// Handshake only after a clean packet end, one cycle wide
	property p_hs_cause; hs.valid |-> $past(rx.pkt_end && !rx.pkt_err); endproperty
	a_hs_cause: assert property (p_hs_cause) else $error("handshake without clean end");
	property p_err_quiet; rx.pkt_end && rx.pkt_err |=> !hs.valid; endproperty
	a_err_quiet: assert property (p_err_quiet) else $error("handshake after error");
	property p_hs_one; s_good_end ##1 hs.valid |=> !hs.valid; endproperty
	a_hs_one: assert property (p_hs_one) else $error("handshake longer than one cycle");
	property p_dead; !circuit_run |-> !hs.valid; endproperty
	a_dead: assert property (p_dead) else $error("handshake while held in reset");
	// Register bus answer timing
	property p_wr_lat; s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
	property p_rd_lat; s_rd_reg |=> !s_axi_rvalid ##1 s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late or early");
	property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_end: assert property (p_b_end) else $error("write answer repeated");
	property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_r_end: assert property (p_r_end) else $error("read answer repeated");
	property p_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
		|=> ##1 s_axi_rresp == RESP_SLVERR; endproperty
	a_bad: assert property (p_bad) else $error("unaligned read not refused");
endmodule
bind usbr_top usbr_chk u_chk (.clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .rx, .hs, .circuit_run);
`default_nettype wire

// [usbr_host.sv]
// Host-side packet source driving the decoded receive stream
`default_nettype none
module usbr_host import usbr_pkg::*; (
	input wire logic clk,
	output var usbr_pkg::usbr_rx_t rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx = '0;
	// Token, n bytes, then end marker; data lines flip once with the end marker
	task automatic xfer(input logic st, input logic [3:0] ep, input int n, input logic odd,
		input logic er);
		@(posedge clk);
		rx.tok_valid <= 1'b1;
		rx.tok_setup <= st;
		rx.tok_ep <= ep;
		rx.data_odd <= odd;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			rx.tok_valid <= 1'b0;
			rx.byte_valid <= 1'b1;
			rx.data <= 8'h11 + i[7:0];
		end
		@(posedge clk);
		rx.tok_valid <= 1'b0;
		rx.byte_valid <= 1'b0;
		rx.data <= ~rx.data;
		rx.pkt_end <= 1'b1;
		rx.pkt_err <= er;
		@(posedge clk);
		rx.pkt_end <= 1'b0;
		rx.pkt_err <= 1'b0;
	endtask
endmodule
`default_nettype wire

// [usb_device_setup_out_handling_tb_top.sv]
// Self-checking bench for the USB setup/OUT transaction engine
`default_nettype none
module usb_device_setup_out_handling_tb_top import usbr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} usbr_row_t;
	localparam usbr_row_t ROWS [9] = '{'{OFS_POWER, 32'h3, 32'h3}, '{OFS_CTRL, 32'hd, 32'hd},
		'{8'h40, 32'h1, 32'h1}, '{8'h50, 32'h104, 32'h104}, '{8'h50, 32'h2104, 32'h2104},
		'{OFS_MAIN_EN, 32'h1, 32'h1}, '{OFS_WR_REQ_EN, 32'h2, 32'h2},
		'{OFS_RD_REQ_EN, 32'h4, 32'h4}, '{8'h44, 32'h2, 32'h2}};
	logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, circuit_run, logic_connected, usb_irq;
	logic [3:0] dma_wr_req, dma_rd_req;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_rresp, s_axi_bresp, bus_line_state = 2'h1, r;
	usbr_rx_t rx;
	usbr_hs_t hs;
	int n_errors = 0, compares = 0, cyc = 0;
	usbr_top dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx, .hs, .bus_line_state, .usb_irq, .dma_wr_req, .dma_rd_req,
		.circuit_run, .logic_connected);
	usbr_host host (.clk(clk), .rx(rx));
	initial forever #20 clk = ~clk;
	// Result bookkeeping
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic note(input string s);
		$display("test %s done", s);
	endtask
	task automatic finish_test;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Register bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		cmp(d, e);
	endtask
	// Packet plus handshake check: 4 means no answer, 7 more than one
	task automatic txn(input logic st, input logic [3:0] ep, input int n, input logic odd,
		input logic er, input logic [2:0] e);
		logic [2:0] s;
		s = 3'h4;
		host.xfer(st, ep, n, odd, er);
		for (int k = 0; k < 3; k++) begin
			#1;
			if (hs.valid === 1'b1) s = (s == 3'h4) ? {1'b0, hs.code} : 3'h7;
			@(posedge clk);
		end
		cmp({29'h0, s}, {29'h0, e});
	endtask
	// Watchdog
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			finish_test;
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		cmp({30'h0, circuit_run, logic_connected}, 32'h0);
		rc(OFS_POWER, 32'h0);
		note("reset");
		foreach (ROWS[i]) begin
			wr(ROWS[i].a, ROWS[i].d);
			rc(ROWS[i].a, ROWS[i].e);
		end
		rc(OFS_LINE, 32'h1);
		wr(OFS_CTRL, 32'hf);
		rd(8'h02);
		cmp({30'h0, r}, 32'h2);
		rd(8'h30);
		cmp({d[29:0], r}, 32'h2);
		wr(8'h03, 32'h0);
		cmp({30'h0, r}, 32'h2);
		note("registers");
		txn(1'b0, 4'h0, 2, 1'b0, 1'b0, 3'h2);
		txn(1'b1, 4'h0, 8, 1'b0, 1'b0, 3'h0);
		rc(OFS_SETUP_LO, 32'h14131211);
		rc(OFS_SETUP_HI, 32'h18171615);
		rc(OFS_MAIN_FLAG, 32'h1);
		cmp({31'h0, usb_irq}, 32'h1);
		rc(8'h44, 32'h5);
		rc(OFS_EP0_IN_CTL, 32'h5);
		wr(OFS_MAIN_FLAG, 32'h1);
		wr(8'h44, 32'h4);
		cmp({31'h0, usb_irq}, 32'h0);
		txn(1'b1, 4'h0, 8, 1'b0, 1'b1, 3'h4);
		rc(OFS_MAIN_FLAG, 32'h0);
		rc(8'h44, 32'h4);
		note("setup");
		txn(1'b0, 4'h1, 3, 1'b0, 1'b0, 3'h0);
		rc(8'h94, 32'h3);
		cmp({24'h0, dma_wr_req, dma_rd_req}, 32'h20);
		rc(8'h58, 32'h3);
		rc(8'h54, 32'h5);
		rc(8'h84, 32'h11);
		wr(8'h58, 32'hf);
		wr(8'h54, 32'h4);
		txn(1'b0, 4'h1, 3, 1'b0, 1'b0, 3'h0);
		rc(8'h94, 32'h2);
		rc(8'h58, 32'h0);
		txn(1'b0, 4'h1, 2, 1'b1, 1'b1, 3'h4);
		rc(8'h58, 32'h8);
		rc(8'h94, 32'h2);
		wr(8'h58, 32'hf);
		wr(8'h50, 32'h2140);
		txn(1'b0, 4'h1, 63, 1'b1, 1'b0, 3'h1);
		rc(8'h58, 32'h4);
		rc(8'h94, 32'h2);
		rc(8'h54, 32'h4);
		note("out");
		wr(OFS_POWER, 32'h0);
		@(posedge clk);
		cmp({30'h0, circuit_run, logic_connected}, 32'h0);
		rc(OFS_CTRL, 32'h0);
		txn(1'b0, 4'h1, 2, 1'b1, 1'b0, 3'h4);
		note("detach");
		finish_test;
	end
endmodule
`default_nettype wire
